// File: inc/reader_seq_map.vh
// register indices, field positions, reset values and command codes
// assumes byte address = 4 * index on a 32-bit bus
`ifndef READER_SEQ_MAP_VH
`define READER_SEQ_MAP_VH
`define IDX_IO_CONF1 6'h00
`define IDX_IO_CONF2 6'h01
`define IDX_OP_CTRL 6'h02
`define IDX_MODE_DEF 6'h03
`define IDX_BIT_RATE 6'h04
`define IDX_EVENTS 6'h17
`define IDX_FIFO_STAT1 6'h1A
`define IDX_FIFO_STAT2 6'h1B
`define IDX_WATER_LVL 6'h1C
`define IDX_NTX1 6'h1D
`define IDX_NTX2 6'h1E
`define IDX_FIFO_DATA 6'h20
`define IDX_DIRECT_CMD 6'h21
`define IDX_CAP_DISPLAY 6'h3D
`define IDX_IDENTITY 6'h3F
`define OP_EN 7
`define OP_RX_EN 6
`define OP_TX_EN 3
`define OP_GAIN_EN 2
`define EV_OSC 0
`define EV_TX_END 1
`define EV_RX_END 2
`define EV_RX_ERR 3
`define EV_COLL 4
`define EV_WATER 5
`define RST_BYTE 8'h00
`define RST_WATER_LVL 8'h48
`define CMD_SET_DEFAULT 8'hC1
`define CMD_CLEAR 8'hC2
`define CMD_TX_CRC 8'hC4
`define CMD_TX_NOCRC 8'hC5
`define CMD_TX_SHORT_REQ 8'hC6
`define CMD_TX_SHORT_WAKE 8'hC7
`define FRAME_SHORT_REQ 8'h26
`define FRAME_SHORT_WAKE 8'h52
`define CRC_INIT 16'h6363
`define CRC_POLY 16'h8408
`endif

// File: src/pin_sync.v
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] pin,
    output reg [W-1:0] level
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            level <= {W{1'b0}};
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // change taken only when stages two and three agree
            level <= (s2_q & s3_q) | (level & (s2_q | s3_q));
        end
    end
endmodule // pin_sync

// File: src/byte_fifo.v
// byte fifo with one push and one pop port, count and flags
// assumes nothing of the caller; pushes when full and pops when empty are dropped
`timescale 1ns/1ps
module byte_fifo #(
    parameter DEPTH = 64,
    parameter AW = 6
) (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire push,
    input wire [7:0] push_data,
    input wire pop,
    output wire [7:0] head,
    output reg [AW:0] count,
    output wire full,
    output wire empty
);
    reg [7:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    assign head = mem[rd_q];
    assign full = (count == DEPTH[AW:0]);
    assign empty = (count == {(AW+1){1'b0}});

    function [AW-1:0] bump;
        input [AW-1:0] p;
        begin
            bump = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
        end
    endfunction

    always @(posedge clk)
    begin
        if (do_push)
            mem[wr_q] <= push_data;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else if (clear)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_push)
                wr_q <= bump(wr_q);
            if (do_pop)
                rd_q <= bump(rd_q);
            if (do_push && !do_pop)
                count <= count + 1'b1;
            else if (do_pop && !do_push)
                count <= count - 1'b1;
        end
    end
endmodule // byte_fifo

// File: src/reader_transceive_sequencer.v
// reader sequencer: ahb-lite registers, direct commands, fifo transmit/receive
// assumes a single ahb-lite master, modulator logic on hclk, receiver pins asynchronous
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "reader_seq_map.vh"
// Behaviour
// [RULE1] capacitance display is read-only, zero after reset and set-default
// [RULE2] identity register: five-bit device type above three-bit revision
// [RULE3] reset leaves device powered down with all registers at defaults
// [RULE4] host first writes both io configuration registers
// [RULE5] host should issue regulator adjustment command during bring-up
// [RULE6] host calibrates antenna and modulation depth when those are used
// [RULE7] host writes mode and bit rate, then analog preset, then options
// [RULE8] main enable bit starts oscillator and regulators, ready mode
// [RULE9] event raised once oscillator is stable after ready entry
// [RULE10] host enables receiver and transmitter, waits with field on
// [RULE11] short request and wake-up frames sent by commands without fifo
// [RULE12] host clears, writes byte count, loads fifo, then issues transmit
// [RULE13] end-of-transmission event after all bytes of frame sent
// [RULE14] after transmit, receiver watched, strength measure and gain control start
// [RULE15] received subcarrier bits decoded into bytes pushed into fifo
// [RULE16] end-of-receive event raised, fifo count shown in two status registers
// [RULE17] reception error or collision raises event with matching flag
// [RULE18] host refills fifo on each transmit watermark event for long frames
// [RULE19] watermark event when fifo bytes left fall below transmit level
// [RULE20] watermark event when fifo occupancy exceeds receive level
// [RULE21] status registers show bytes still unread at end of long reception
// [RULE22] payload stops at programmed count, crc appended only for crc command
module reader_transceive_sequencer #(
    parameter FIFO_DEPTH = 64,
    parameter FIFO_AW = 6,
    parameter [4:0] DEVICE_TYPE = 5'h15, // arbitrary
    parameter [2:0] SILICON_REV = 3'h5 // arbitrary
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire osc_stable,
    input wire receive_antenna_inputs,
    input wire rx_bit_strobe,
    input wire rx_frame_active,
    input wire rx_error_in,
    input wire rx_collision_in,
    input wire tx_ready,
    input wire [7:0] cap_meas_value,
    input wire cap_meas_done,
    output reg osc_enable,
    output reg regulator_enable,
    output reg field_enable,
    output reg receiver_enable,
    output reg [7:0] tx_byte,
    output reg tx_byte_valid,
    output reg signal_strength_measure,
    output reg gain_control,
    output reg irq
);
    localparam ST_IDLE = 3'd0;
    localparam ST_TXD = 3'd1;
    localparam ST_TXC = 3'd2;
    localparam ST_RXW = 3'd3;
    localparam ST_RX = 3'd4;

    reg [7:0] io_conf1_q;
    reg [7:0] io_conf2_q;
    reg [7:0] op_ctrl_q;
    reg [7:0] mode_q;
    reg [7:0] bit_rate_q;
    reg [7:0] water_q;
    reg [7:0] ntx1_q;
    reg [7:0] ntx2_q;
    reg [7:0] cap_disp_q;
    reg [5:0] events_q;
    reg [2:0] state_q;
    reg [15:0] remain_q;
    reg [15:0] crc_q;
    reg crc_mode_q;
    reg crc_hi_q;
    reg [7:0] shift_q;
    reg [2:0] bit_cnt_q;
    reg osc_seen_q;
    reg below_q;
    reg above_q;
    reg wr_pend_q;
    reg [5:0] wr_idx_q;
    reg [4:0] pins_q;
    reg [31:0] rd_val;
    reg [5:0] ev_set;

    wire [4:0] pins;
    wire osc_ok = pins[0];
    wire rx_bit = pins[1];
    wire rx_active = pins[3];
    wire [4:0] pins_rise = pins & ~pins_q;
    wire rx_strobe_rise_w = pins_rise[2];
    wire rx_active_fall = pins_q[3] & ~pins[3];
    reg coll_q;

    wire addr_ph = hsel && htrans[1] && hready;
    wire mapped = (haddr[31:8] == 24'h000000);
    wire [5:0] a_idx = haddr[7:2];
    wire bus_rd = addr_ph && !hwrite && mapped;
    wire wr_now = wr_pend_q;
    wire [7:0] wbyte = hwdata[7:0];
    wire cmd_wr = wr_now && (wr_idx_q == `IDX_DIRECT_CMD);
    wire set_default = cmd_wr && (wbyte == `CMD_SET_DEFAULT);
    wire cmd_clear = cmd_wr && (wbyte == `CMD_CLEAR);
    wire field_on = op_ctrl_q[`OP_EN] && op_ctrl_q[`OP_TX_EN];
    wire idle_ready = (state_q == ST_IDLE) && field_on;

    wire [7:0] fifo_head;
    wire [FIFO_AW:0] fifo_cnt;
    wire fifo_full;
    wire fifo_empty;
    wire rx_push = (state_q == ST_RX) && rx_strobe_rise_w && (bit_cnt_q == 3'd7);
    wire [7:0] rx_byte = {rx_bit, shift_q[7:1]};
    wire bus_push = wr_now && (wr_idx_q == `IDX_FIFO_DATA) && !rx_push;
    wire tx_pop = (state_q == ST_TXD) && !tx_byte_valid && (remain_q != 16'h0000) && !fifo_empty;
    wire bus_pop = bus_rd && (a_idx == `IDX_FIFO_DATA);
    wire [7:0] tx_lvl = {4'h0, water_q[3:0]};
    wire [7:0] rx_lvl = {4'h0, water_q[7:4]};
    wire [8:0] cnt9 = {{(8 - FIFO_AW){1'b0}}, fifo_cnt};
    wire below_now = (state_q == ST_TXD) && (cnt9 < {1'b0, tx_lvl});
    wire above_now = (state_q == ST_RX) && (cnt9 > {1'b0, rx_lvl});
    pin_sync #(
        .W(5)
    ) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .pin({rx_error_in, rx_frame_active, rx_bit_strobe, receive_antenna_inputs, osc_stable}),
        .level(pins)
    );

    byte_fifo #(
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .clear(cmd_clear || set_default),
        .push(rx_push || bus_push),
        .push_data(rx_push ? rx_byte : wbyte),
        .pop(tx_pop || bus_pop),
        .head(fifo_head),
        .count(fifo_cnt),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    wire coll_sync;
    pin_sync #(
        .W(1)
    ) u_sync_coll (
        .clk(hclk),
        .rst_n(hresetn),
        .pin(rx_collision_in),
        .level(coll_sync)
    );

    function [15:0] crc_step;
        input [15:0] c;
        input [7:0] d;
        integer i;
        reg [15:0] t;
        begin
            t = c ^ {8'h00, d};
            for (i = 0; i < 8; i = i + 1)
                t = t[0] ? ((t >> 1) ^ `CRC_POLY) : (t >> 1);
            crc_step = t;
        end
    endfunction

    // read mux
    always @*
    begin
        rd_val = 32'h00000000;
        case (a_idx)
            `IDX_IO_CONF1: rd_val[7:0] = io_conf1_q;
            `IDX_IO_CONF2: rd_val[7:0] = io_conf2_q;
            `IDX_OP_CTRL: rd_val[7:0] = op_ctrl_q;
            `IDX_MODE_DEF: rd_val[7:0] = mode_q;
            `IDX_BIT_RATE: rd_val[7:0] = bit_rate_q;
            `IDX_EVENTS: rd_val[5:0] = events_q;
            `IDX_FIFO_STAT1: rd_val[7:0] = cnt9[7:0]; // [RULE16] [RULE21]
            `IDX_FIFO_STAT2: rd_val[0] = cnt9[8]; // [RULE16] [RULE21]
            `IDX_WATER_LVL: rd_val[7:0] = water_q;
            `IDX_NTX1: rd_val[7:0] = ntx1_q;
            `IDX_NTX2: rd_val[7:0] = ntx2_q;
            `IDX_FIFO_DATA: rd_val[7:0] = fifo_empty ? 8'h00 : fifo_head;
            `IDX_CAP_DISPLAY: rd_val[7:0] = cap_disp_q; // [RULE1]
            `IDX_IDENTITY: rd_val[7:0] = {DEVICE_TYPE, SILICON_REV}; // [RULE2]
            default: ;
        endcase
        if (!mapped)
            rd_val = 32'h00000000;
    end

    // event sources
    always @*
    begin
        ev_set = 6'h00;
        ev_set[`EV_OSC] = op_ctrl_q[`OP_EN] && osc_ok && !osc_seen_q; // [RULE9]
        ev_set[`EV_WATER] = (below_now && !below_q) || (above_now && !above_q); // [RULE19] [RULE20]
        ev_set[`EV_RX_ERR] = (state_q == ST_RX) && pins_rise[4]; // [RULE17]
        ev_set[`EV_COLL] = (state_q == ST_RX) && coll_sync && !coll_q; // [RULE17]
        ev_set[`EV_RX_END] = (state_q == ST_RX) && rx_active_fall; // [RULE16]
        ev_set[`EV_TX_END] = ((state_q == ST_TXD) && !tx_byte_valid && (remain_q == 16'h0000) && !crc_mode_q)
            || ((state_q == ST_TXC) && tx_byte_valid && tx_ready && crc_hi_q); // [RULE13]
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_idx_q <= 6'h00;
            pins_q <= 5'h00;
            coll_q <= 1'b0;
            below_q <= 1'b0;
            above_q <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= addr_ph && hwrite && mapped;
            wr_idx_q <= a_idx;
            if (addr_ph)
                hrdata <= hwrite ? 32'h00000000 : rd_val;
            pins_q <= pins;
            coll_q <= coll_sync;
            below_q <= below_now;
            above_q <= above_now;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // [RULE3] power-down, every register at default
            {io_conf1_q, io_conf2_q, op_ctrl_q, mode_q, bit_rate_q, ntx1_q, ntx2_q} <= {7{`RST_BYTE}};
            water_q <= `RST_WATER_LVL;
            cap_disp_q <= `RST_BYTE;
            events_q <= 6'h00;
            state_q <= ST_IDLE;
            remain_q <= 16'h0000;
            crc_q <= `CRC_INIT;
            {crc_mode_q, crc_hi_q, osc_seen_q, tx_byte_valid} <= 4'h0;
            shift_q <= 8'h00;
            bit_cnt_q <= 3'd0;
            tx_byte <= 8'h00;
            {osc_enable, regulator_enable, field_enable, receiver_enable} <= 4'h0;
            {signal_strength_measure, gain_control, irq} <= 3'h0;
        end
        else if (set_default)
        begin
            {io_conf1_q, io_conf2_q, op_ctrl_q, mode_q, bit_rate_q, ntx1_q, ntx2_q} <= {7{`RST_BYTE}}; // [RULE3]
            water_q <= `RST_WATER_LVL;
            cap_disp_q <= `RST_BYTE; // [RULE1]
            events_q <= 6'h00;
            state_q <= ST_IDLE;
            remain_q <= 16'h0000;
            bit_cnt_q <= 3'd0;
            {crc_mode_q, crc_hi_q, osc_seen_q, tx_byte_valid} <= 4'h0;
            {osc_enable, regulator_enable, field_enable, receiver_enable} <= 4'h0;
            {signal_strength_measure, gain_control, irq} <= 3'h0;
        end
        else
        begin
            // register writes in the data phase
            if (wr_now)
            begin
                case (wr_idx_q)
                    `IDX_IO_CONF1: io_conf1_q <= wbyte;
                    `IDX_IO_CONF2: io_conf2_q <= wbyte;
                    `IDX_OP_CTRL: op_ctrl_q <= wbyte;
                    `IDX_MODE_DEF: mode_q <= wbyte;
                    `IDX_BIT_RATE: bit_rate_q <= wbyte;
                    `IDX_WATER_LVL: water_q <= wbyte;
                    `IDX_NTX1: ntx1_q <= wbyte;
                    `IDX_NTX2: ntx2_q <= wbyte;
                    default: ;
                endcase
            end
            if (cap_meas_done)
                cap_disp_q <= cap_meas_value;
            // event flags clear on read, a set in the same cycle wins
            events_q <= ((bus_rd && (a_idx == `IDX_EVENTS)) ? 6'h00 : events_q) | ev_set;
            irq <= |(events_q | ev_set);
            // ready mode
            osc_enable <= op_ctrl_q[`OP_EN]; // [RULE8]
            regulator_enable <= op_ctrl_q[`OP_EN]; // [RULE8]
            field_enable <= field_on;
            if (!op_ctrl_q[`OP_EN])
                osc_seen_q <= 1'b0;
            else if (osc_ok)
                osc_seen_q <= 1'b1; // [RULE9]
            if (tx_byte_valid && tx_ready)
                tx_byte_valid <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    receiver_enable <= 1'b0;
                    if (idle_ready && cmd_wr)
                    begin
                        crc_q <= `CRC_INIT;
                        crc_hi_q <= 1'b0;
                        if (wbyte == `CMD_TX_SHORT_REQ || wbyte == `CMD_TX_SHORT_WAKE)
                        begin
                            // [RULE11] fixed frame, fifo untouched
                            tx_byte <= (wbyte == `CMD_TX_SHORT_REQ) ? `FRAME_SHORT_REQ : `FRAME_SHORT_WAKE;
                            tx_byte_valid <= 1'b1;
                            remain_q <= 16'h0000;
                            crc_mode_q <= 1'b0;
                            state_q <= ST_TXD;
                        end
                        else if (wbyte == `CMD_TX_CRC || wbyte == `CMD_TX_NOCRC)
                        begin
                            remain_q <= {ntx1_q, ntx2_q}; // [RULE22]
                            crc_mode_q <= (wbyte == `CMD_TX_CRC); // [RULE22]
                            state_q <= ST_TXD;
                        end
                    end
                end
                ST_TXD:
                begin
                    if (tx_pop)
                    begin
                        tx_byte <= fifo_head;
                        tx_byte_valid <= 1'b1;
                        crc_q <= crc_step(crc_q, fifo_head);
                        remain_q <= remain_q - 16'h0001; // [RULE22]
                    end
                    else if (!tx_byte_valid && remain_q == 16'h0000)
                    begin
                        if (crc_mode_q)
                        begin
                            tx_byte <= crc_q[7:0]; // [RULE22]
                            tx_byte_valid <= 1'b1;
                            state_q <= ST_TXC;
                        end
                        else
                            state_q <= ST_RXW; // [RULE13]
                    end
                end
                ST_TXC:
                begin
                    if (tx_byte_valid && tx_ready)
                    begin
                        if (!crc_hi_q)
                        begin
                            tx_byte <= crc_q[15:8];
                            tx_byte_valid <= 1'b1;
                            crc_hi_q <= 1'b1;
                        end
                        else
                            state_q <= ST_RXW; // [RULE13]
                    end
                end
                ST_RXW:
                begin
                    // [RULE14] watch receiver, start measurement and gain control
                    receiver_enable <= op_ctrl_q[`OP_RX_EN];
                    signal_strength_measure <= 1'b1;
                    gain_control <= op_ctrl_q[`OP_GAIN_EN];
                    bit_cnt_q <= 3'd0;
                    if (rx_active)
                        state_q <= ST_RX;
                end
                ST_RX:
                begin
                    if (rx_strobe_rise_w)
                    begin
                        shift_q <= rx_byte; // [RULE15]
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                    end
                    if (rx_active_fall)
                    begin
                        signal_strength_measure <= 1'b0;
                        gain_control <= 1'b0;
                        receiver_enable <= 1'b0;
                        state_q <= ST_IDLE; // [RULE16]
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (cmd_clear)
            begin
                state_q <= ST_IDLE;
                tx_byte_valid <= 1'b0;
                signal_strength_measure <= 1'b0;
                gain_control <= 1'b0;
            end
        end
    end
endmodule // reader_transceive_sequencer

// File: bench/reader_seq_assertions.sv
// checker: bus answers and front end handshake of the sequencer
// assumes binding to the sequencer's top ports
`timescale 1ns/1ps
module reader_seq_assertions (
    input wire hclk,
    input wire hresetn,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire tx_ready,
    input wire [7:0] tx_byte,
    input wire tx_byte_valid,
    input wire osc_enable,
    input wire regulator_enable,
    input wire field_enable,
    input wire receiver_enable,
    input wire signal_strength_measure,
    input wire gain_control
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    a_byte_wide: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_regs_with_osc: assert property (osc_enable == regulator_enable)
        else $error("regulator mismatch");
    a_field_ready: assert property (field_enable |-> osc_enable)
        else $error("field without ready mode");
    a_tx_byte_held: assert property (tx_byte_valid && !tx_ready |=> tx_byte_valid && $stable(tx_byte))
        else $error("tx byte dropped");
    a_listen_no_tx: assert property (receiver_enable |-> !tx_byte_valid)
        else $error("sending while listening");
    a_meas_on_listen: assert property ($rose(receiver_enable) |-> signal_strength_measure)
        else $error("measure not started");
    a_gain_in_meas: assert property (gain_control |-> signal_strength_measure)
        else $error("gain without measure");
endmodule // reader_seq_assertions
bind reader_transceive_sequencer reader_seq_assertions chk (.*);

// File: bench/rf_front_model.sv
// front end model: modulator acceptance and receiver pins
// assumes the sequencer clock; pins change after rising edges
`timescale 1ns/1ps
module rf_front_model (
    input wire hclk,
    input wire tx_byte_valid,
    output reg tx_ready,
    output reg receive_antenna_inputs,
    output reg rx_bit_strobe,
    output reg rx_frame_active,
    output reg rx_error_in,
    output reg rx_collision_in
);
    integer seed = 13;
    initial
    begin
        {tx_ready, receive_antenna_inputs, rx_bit_strobe, rx_frame_active, rx_error_in, rx_collision_in} = 6'h00;
    end
    // random acceptance; data toggles outside frames
    always @(posedge hclk)
    begin
        tx_ready <= 1'($random(seed));
        if (!rx_frame_active)
            receive_antenna_inputs <= ~receive_antenna_inputs;
    end
    task hold;
        repeat (6) @(posedge hclk);
    endtask
    // lsb first, levels held six cycles
    task frame(input logic [7:0] q[$], input bit er, input bit co);
        integer i;
        begin
            rx_frame_active <= 1'b1;
            hold;
            for (i = 0; i < 8 * q.size(); i++)
            begin
                receive_antenna_inputs <= q[i / 8][i % 8];
                hold;
                rx_bit_strobe <= 1'b1;
                hold;
                rx_bit_strobe <= 1'b0;
                hold;
            end
            rx_error_in <= er;
            rx_collision_in <= co;
            hold;
            {rx_error_in, rx_collision_in, rx_frame_active} <= 3'h0;
            hold;
        end
    endtask
endmodule // rf_front_model

// File: bench/reader_transceive_sequencer_tb_top.sv
// testbench: ahb master, expectation queues, verdict
// assumes the front end model and the bound checker
`timescale 1ns/1ps
`include "reader_seq_map.vh"
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, e, s); end end
module reader_transceive_sequencer_tb_top;
    localparam [4:0] TYPE_ID = 5'h0A; // arbitrary value
    localparam [2:0] REV_ID = 3'h6; // arbitrary value
    reg hclk, hresetn, hsel, hwrite, osc_stable, cap_meas_done, rd_dp;
    reg [1:0] htrans;
    reg [31:0] haddr, hwdata;
    reg [7:0] cap_meas_value, b, e_v, m_v, t_v;
    reg [15:0] c;
    wire [31:0] hrdata;
    wire [7:0] tx_byte;
    wire hreadyout, hresp, tx_ready, receive_antenna_inputs, rx_bit_strobe, rx_frame_active, rx_error_in;
    wire rx_collision_in, osc_enable, regulator_enable, field_enable, receiver_enable, tx_byte_valid;
    wire signal_strength_measure, gain_control, irq;
    wire [2:0] mon = {irq, receiver_enable, hreadyout};
    integer seed = 13, err_total = 0, compares = 0, i, k, n;
    logic [7:0] exp_q[$], msk_q[$], tx_q[$], rq[$];
    reader_transceive_sequencer #(.DEVICE_TYPE(TYPE_ID), .SILICON_REV(REV_ID))
        dut (.*, .hsize(3'h2), .hready(hreadyout));
    rf_front_model fe (.*);
    function [15:0] crc(input [15:0] r, input [7:0] d);
        integer j;
        begin
            crc = r ^ {8'h00, d};
            for (j = 0; j < 8; j++)
                crc = crc[0] ? (crc >> 1) ^ `CRC_POLY : crc >> 1;
        end
    endfunction
    task stop_test;
        begin
            if (err_total == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task wait_for(input integer s, input bit v);
        begin
            k = 0;
            @(posedge hclk);
            while (mon[s] !== v)
            begin
                k++;
                if (k > 3000)
                begin
                    err_total++;
                    stop_test;
                end
                @(posedge hclk);
            end
        end
    endtask
    task bus(input [5:0] x, input bit w, input [7:0] d);
        begin
            {hsel, htrans, haddr, hwrite} <= {3'h6, 24'h0, x, 2'h0, w};
            wait_for(0, 1'b1);
            {hsel, htrans, rd_dp} <= {3'h0, !w};
            hwdata <= {24'h0, d};
            wait_for(0, 1'b1);
            rd_dp <= 1'b0;
        end
    endtask
    task rd(input [5:0] x, input [7:0] e, input [7:0] m = 8'hFF);
        begin
            exp_q.push_back(e & m);
            msk_q.push_back(m);
            @(posedge hclk);
            bus(x, 1'b0, 8'h00);
        end
    endtask
    // read data and accepted tx bytes against the oldest notes
    always @(posedge hclk)
    begin
        if (rd_dp && hreadyout)
        begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            `CHK("read data", {24'h0, e_v}, hrdata & {24'hFFFFFF, m_v})
        end
        if (tx_byte_valid && tx_ready)
        begin
            t_v = tx_q.pop_front();
            `CHK("tx byte", t_v, tx_byte)
        end
    end
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial
    begin
        {hsel, hwrite, osc_stable, cap_meas_done, rd_dp, htrans, haddr, hwdata, cap_meas_value} = 0;
        hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`IDX_CAP_DISPLAY, `RST_BYTE);
        rd(`IDX_IDENTITY, {TYPE_ID, REV_ID});
        rd(`IDX_WATER_LVL, `RST_WATER_LVL);
        rd(`IDX_OP_CTRL, `RST_BYTE);
        rd(6'h3E, 8'h00);
        bus(`IDX_CAP_DISPLAY, 1'b1, 8'hFF);
        rd(`IDX_CAP_DISPLAY, `RST_BYTE);
        b = 8'($random(seed));
        {cap_meas_value, cap_meas_done} <= {b, 1'b1};
        @(posedge hclk);
        cap_meas_done <= 1'b0;
        rd(`IDX_CAP_DISPLAY, b);
        bus(`IDX_DIRECT_CMD, 1'b1, `CMD_SET_DEFAULT);
        rd(`IDX_CAP_DISPLAY, `RST_BYTE);
        bus(`IDX_IO_CONF1, 1'b1, 8'($random(seed)));
        bus(`IDX_IO_CONF2, 1'b1, 8'($random(seed)));
        bus(`IDX_DIRECT_CMD, 1'b1, 8'hD6);
        bus(`IDX_MODE_DEF, 1'b1, 8'h00);
        bus(`IDX_BIT_RATE, 1'b1, 8'h00);
        bus(`IDX_OP_CTRL, 1'b1, 8'h80);
        osc_stable <= 1'b1;
        wait_for(2, 1'b1);
        rd(`IDX_EVENTS, 8'h01, 8'h01);
        bus(`IDX_OP_CTRL, 1'b1, 8'hCC);
        // req, wake, plain, crc+err, crc+coll, long
        for (i = 0; i < 6; i++)
        begin
            bus(`IDX_DIRECT_CMD, 1'b1, `CMD_CLEAR);
            n = (i == 5) ? 10 : 3;
            c = `CRC_INIT;
            if (i < 2)
                tx_q.push_back(i ? `FRAME_SHORT_WAKE : `FRAME_SHORT_REQ);
            else
            begin
                bus(`IDX_NTX1, 1'b1, 8'h00);
                bus(`IDX_NTX2, 1'b1, 8'(n));
                repeat (n)
                begin
                    b = 8'($random(seed));
                    bus(`IDX_FIFO_DATA, 1'b1, b);
                    tx_q.push_back(b);
                    c = crc(c, b);
                end
            end
            if (i == 3 || i == 4)
                tx_q = {tx_q, c[7:0], c[15:8]};
            rq = {};
            repeat ((i == 5) ? 6 : 2)
                rq.push_back(8'($random(seed)));
            bus(`IDX_DIRECT_CMD, 1'b1, i < 2 ? (i ? `CMD_TX_SHORT_WAKE : `CMD_TX_SHORT_REQ)
                : ((i == 3 || i == 4) ? `CMD_TX_CRC : `CMD_TX_NOCRC));
            wait_for(1, 1'b1);
            `CHK("gain control", 1'b1, gain_control)
            fe.frame(rq, i == 3, i == 4);
            wait_for(1, 1'b0);
            rd(`IDX_EVENTS, {2'h0, i == 5, i == 4, i == 3, 3'h6}, (i == 5) ? 8'h3E : 8'h1E);
            rd(`IDX_FIFO_STAT1, 8'(rq.size()));
            rd(`IDX_FIFO_STAT2, 8'h00);
            rd(`IDX_FIFO_DATA, rq[0]);
        end
        `CHK("tx bytes left", 0, tx_q.size())
        stop_test;
    end
endmodule // reader_transceive_sequencer_tb_top
